// >>> rtl/remote_message_front_end.sv
// Purpose: Byte stream front end: protocol pick, message delimiting, idle close, limit checks.
// Assumes: Bytes arrive one per cycle at most with a link type and socket port beside them.
// Notes:   Command decoding lies behind this block; it sees forwarded bytes and end pulses.
`timescale 1ns/100ps
`include "rmfe_cfg.svh"
module remote_message_front_end #(
    parameter int MS_CYCLES = `RMFE_MS_CYCLES,
    parameter int MS_PER_S  = `RMFE_MS_PER_S,
    parameter int NUM_SOCK  = 4,
    parameter int SW        = 2
) (
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_b,
    // Receive stream
    input  wire rmfe_pkg::link_type  i_link,
    input  wire logic [15:0]         i_rx_port,
    input  wire logic                i_rx_valid,
    input  wire logic [7:0]          i_rx_byte,
    input  wire logic [SW-1:0]       i_rx_sock,
    // Transmit activity and sockets
    input  wire logic                i_tx_valid,
    input  wire logic [SW-1:0]       i_tx_sock,
    input  wire logic [NUM_SOCK-1:0] i_sock_open,
    input  wire logic                i_resp_sent,
    // Settings
    input  wire logic                i_gap_local_wr,
    input  wire logic                i_gap_remote_wr,
    input  wire logic [7:0]          i_gap_ms,
    input  wire logic [7:0]          i_idle_s,
    input  wire logic                i_keep_alive,
    // Set values and limits
    input  wire logic                i_setv_valid,
    input  wire logic [15:0]         i_setv_value,
    input  wire logic                i_setv_scpi,
    input  wire logic [15:0]         i_lim_low,
    input  wire logic [15:0]         i_lim_high,
    input  wire logic                i_err_query,
    // Forwarded message
    output logic                     o_fwd_valid,
    output logic [7:0]               o_fwd_byte,
    output logic                     o_fwd_first,
    output logic                     o_msg_done,
    output rmfe_pkg::proto_type      o_msg_proto,
    output logic                     o_comm_err,
    // Status
    output logic [7:0]               o_gap_value,
    output logic [NUM_SOCK-1:0]      o_sock_close,
    output logic                     o_resp_late,
    output logic                     o_setv_accept,
    output logic                     o_setv_reject,
    output logic                     o_err_pending,
    output logic                     o_err_report
);
    localparam int CW = $clog2(MS_CYCLES + 1);

    rmfe_pkg::rx_state_type state_reg;
    rmfe_pkg::rx_state_type state_next;
    rmfe_pkg::proto_type    proto_next;
    logic [CW-1:0]          gap_sub_reg;
    logic [7:0]             gap_ms_reg;
    logic [2:0]             byte_idx_reg;
    logic                   resp_wait_reg;
    logic [7:0]             resp_ms_reg;
    logic                   ms_tick;
    logic                   s_tick;

    // First-byte protocol choice
    function automatic rmfe_pkg::proto_type classify(input logic [7:0] b,
                                                     input rmfe_pkg::link_type l,
                                                     input logic tcp_port);
        if (tcp_port) begin
            classify = rmfe_pkg::PROTO_TCP;
        end else if (b == `RMFE_RTU_ADDR) begin
            classify = (l == rmfe_pkg::LINK_GPIB) ? rmfe_pkg::PROTO_ERR : rmfe_pkg::PROTO_RTU;
        end else if (b < `RMFE_SCPI_MIN) begin
            classify = rmfe_pkg::PROTO_ERR;
        end else begin
            classify = (l == rmfe_pkg::LINK_CAN) ? rmfe_pkg::PROTO_ERR : rmfe_pkg::PROTO_SCPI;
        end
    endfunction

    // Byte decode
    wire rx_lf      = (i_rx_byte == `RMFE_CHAR_LF);
    wire rx_cr      = (i_rx_byte == `RMFE_CHAR_CR);
    wire tcp_port   = (i_link == rmfe_pkg::LINK_ETH) && (i_rx_port == `RMFE_MBTCP_PORT);
    wire in_body    = (state_reg == rmfe_pkg::RX_BODY);
    wire start_msg  = i_rx_valid && ((state_reg == rmfe_pkg::RX_IDLE) ||
                      (state_reg == rmfe_pkg::RX_TERM && !rx_lf));
    wire term_hit   = i_rx_valid && in_body && (o_msg_proto == rmfe_pkg::PROTO_SCPI) &&
                      (rx_lf || rx_cr);
    wire body_byte  = i_rx_valid && in_body && !term_hit;
    wire rmfe_pkg::proto_type first_proto = classify(i_rx_byte, i_link, tcp_port);

    // Header check: protocol id bytes of the MBAP header must be zero
    wire mbap_bad   = body_byte && (o_msg_proto == rmfe_pkg::PROTO_TCP) && (i_rx_byte != 8'h00) &&
                      (byte_idx_reg == `RMFE_MBAP_PID_LO || byte_idx_reg == `RMFE_MBAP_PID_HI);

    // Gap expiry: exactly the set number of ms after the latest byte
    wire gap_tick   = (gap_sub_reg == CW'(MS_CYCLES - 1));
    wire gap_expire = (state_reg != rmfe_pkg::RX_IDLE) && !i_rx_valid && gap_tick &&
                      (gap_ms_reg == o_gap_value - 8'h01);
    wire body_gap   = gap_expire && in_body;
    wire tcp_short  = body_gap && (o_msg_proto == rmfe_pkg::PROTO_TCP) &&
                      (byte_idx_reg < `RMFE_MBTCP_MIN_BYTES);

    // Next state and protocol
    assign state_next = start_msg                ? rmfe_pkg::RX_BODY :
                        (term_hit && rx_cr)      ? rmfe_pkg::RX_TERM :
                        (term_hit || gap_expire || (i_rx_valid && !in_body)) ? rmfe_pkg::RX_IDLE :
                        state_reg;
    assign proto_next = start_msg               ? first_proto :
                        (mbap_bad || tcp_short) ? rmfe_pkg::PROTO_ERR :
                        o_msg_proto;

    // Answers and events
    wire done_next  = term_hit || body_gap;
    wire err_next   = (start_msg && first_proto == rmfe_pkg::PROTO_ERR) || mbap_bad || tcp_short;
    wire fwd_next   = (start_msg && first_proto != rmfe_pkg::PROTO_ERR) ||
                      (body_byte && o_msg_proto != rmfe_pkg::PROTO_ERR && !mbap_bad);
    // Zero would wrap to a 256 ms gap, so it loads 1 ms
    wire [7:0] gap_set = (i_gap_ms == 8'h00) ? 8'h01 : i_gap_ms;

    // Receive state, protocol and forwarding
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg   <= rmfe_pkg::RX_IDLE;
            o_msg_proto <= rmfe_pkg::PROTO_RTU;
            o_fwd_valid <= 1'b0;
            o_fwd_byte  <= 8'h00;
            o_fwd_first <= 1'b0;
            o_msg_done  <= 1'b0;
            o_comm_err  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            o_msg_proto <= proto_next;
            o_fwd_valid <= fwd_next;
            o_fwd_byte  <= i_rx_valid ? i_rx_byte : o_fwd_byte;
            o_fwd_first <= start_msg;
            o_msg_done  <= done_next;
            o_comm_err  <= err_next;
        end
    end

    // Inter-byte timer and byte position; any byte restarts the timer
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_sub_reg  <= '0;
            gap_ms_reg   <= 8'h00;
            byte_idx_reg <= 3'h0;
        end else begin
            if (i_rx_valid || state_reg == rmfe_pkg::RX_IDLE) begin
                gap_sub_reg <= '0;
                gap_ms_reg  <= 8'h00;
            end else begin
                gap_sub_reg <= gap_tick ? '0 : gap_sub_reg + 1'b1;
                gap_ms_reg  <= gap_tick ? gap_ms_reg + 8'h01 : gap_ms_reg;
            end
            if (start_msg) begin
                byte_idx_reg <= 3'h1;
            end else if (body_byte && byte_idx_reg != 3'h7) begin
                byte_idx_reg <= byte_idx_reg + 3'h1;
            end
        end
    end

    // Gap setting: local menu and remote command share one register, either write loads gap_set
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_gap_value <= `RMFE_GAP_DEFAULT_MS;
        end else if (i_gap_local_wr || i_gap_remote_wr) begin
            o_gap_value <= gap_set;
        end
    end

    // Response budget per link; serial and GPIB use the USB figure
    wire [7:0] resp_budget = (i_link == rmfe_pkg::LINK_ETH) ? `RMFE_RESP_ETH_MS :
                             (i_link == rmfe_pkg::LINK_CAN) ? `RMFE_RESP_CAN_MS : `RMFE_RESP_USB_MS;
    wire resp_over = resp_wait_reg && ms_tick && (resp_ms_reg == resp_budget - 8'h01);

    // Answer watchdog; flags a late answer to the processing side
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            resp_wait_reg <= 1'b0;
            resp_ms_reg   <= 8'h00;
            o_resp_late   <= 1'b0;
        end else begin
            o_resp_late <= resp_over && !i_resp_sent;
            if (done_next && proto_next != rmfe_pkg::PROTO_ERR) begin
                resp_wait_reg <= 1'b1;
                resp_ms_reg   <= 8'h00;
            end else if (i_resp_sent || resp_over) begin
                resp_wait_reg <= 1'b0;
            end else if (resp_wait_reg && ms_tick) begin
                resp_ms_reg <= resp_ms_reg + 8'h01;
            end
        end
    end

    // Limit check applies to every control location alike
    wire setv_ok = (i_setv_value >= i_lim_low) && (i_setv_value <= i_lim_high);
    wire scpi_fail = i_setv_valid && !setv_ok && i_setv_scpi;

    // SCPI errors wait for a query; a new failure in the query cycle stays pending
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_setv_accept <= 1'b0;
            o_setv_reject <= 1'b0;
            o_err_pending <= 1'b0;
            o_err_report  <= 1'b0;
        end else begin
            o_setv_accept <= i_setv_valid && setv_ok;
            o_setv_reject <= i_setv_valid && !setv_ok && !i_setv_scpi;
            o_err_report  <= i_err_query && o_err_pending;
            o_err_pending <= scpi_fail || (o_err_pending && !i_err_query);
        end
    end

    // Time base
    rmfe_tick_gen #(
        .MS_CYCLES (MS_CYCLES),
        .MS_PER_S  (MS_PER_S)
    ) u_tick (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .o_ms_tick  (ms_tick),
        .o_s_tick   (s_tick)
    );

    // Socket idle timers
    rmfe_idle_timers #(
        .NUM_SOCK (NUM_SOCK),
        .SW       (SW)
    ) u_idle (
        .i_core_clk   (i_core_clk),
        .i_rst_b      (i_rst_b),
        .i_s_tick     (s_tick),
        .i_timeout_s  (i_idle_s),
        .i_keep_alive (i_keep_alive),
        .i_sock_open  (i_sock_open),
        .i_rx_valid   (i_rx_valid),
        .i_rx_sock    (i_rx_sock),
        .i_tx_valid   (i_tx_valid),
        .i_tx_sock    (i_tx_sock),
        .o_close      (o_sock_close)
    );

    // Core clock; reset disables every check
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // Delimiting
    gap_restart_a: assert property (i_rx_valid |=> gap_ms_reg == 8'h00 && gap_sub_reg == '0)
        else $error("byte did not restart gap timer");

    gap_full_a: assert property (o_msg_done && !$past(term_hit) |->
        $past(gap_ms_reg) == $past(o_gap_value) - 8'h01 && $past(gap_tick))
        else $error("message ended before full gap");

    gap_end_a: assert property (body_gap |=> o_msg_done && state_reg == rmfe_pkg::RX_IDLE)
        else $error("gap expiry did not end message");

    term_end_a: assert property (term_hit |=> o_msg_done && !o_fwd_valid)
        else $error("terminator did not end message");

    // Protocol choice
    tcp_port_a: assert property (start_msg && tcp_port |=> o_msg_proto == rmfe_pkg::PROTO_TCP)
        else $error("port 502 message not taken as TCP");

    low_byte_a: assert property (start_msg && !tcp_port && i_rx_byte != 8'h00 &&
        i_rx_byte < `RMFE_SCPI_MIN |=> o_comm_err && !o_fwd_valid) else $error("byte 1..41 not an error");

    scpi_pick_a: assert property (start_msg && !tcp_port && i_rx_byte >= `RMFE_SCPI_MIN &&
        i_link != rmfe_pkg::LINK_CAN |=> o_msg_proto == rmfe_pkg::PROTO_SCPI && o_fwd_first)
        else $error("text byte not taken as SCPI");

    gpib_rtu_a: assert property (start_msg && i_link == rmfe_pkg::LINK_GPIB &&
        i_rx_byte == `RMFE_RTU_ADDR |=> o_comm_err) else $error("RTU accepted on GPIB");

    mbap_check_a: assert property (mbap_bad |=> o_comm_err ##1 o_msg_proto == rmfe_pkg::PROTO_ERR)
        else $error("bad MBAP header not flagged");

    short_tcp_a: assert property (tcp_short |=> o_comm_err && o_msg_done)
        else $error("short TCP frame not refused");

    // Set values and answers
    limit_gate_a: assert property (i_setv_valid && !setv_ok |=> !o_setv_accept)
        else $error("out-of-limit value accepted");

    scpi_hold_a: assert property (o_err_pending && !i_err_query |=> o_err_pending && !o_err_report)
        else $error("SCPI error dropped without query");

    resp_late_a: assert property (o_resp_late |-> $past(resp_ms_reg) == $past(resp_budget) - 8'h01)
        else $error("late answer flagged at wrong time");

    err_report_a: assert property (o_err_report |-> $past(i_err_query) && $past(o_err_pending))
        else $error("error reported without query");

    // Main scenarios
    scpi_msg_c: cover property (term_hit ##1 o_msg_done);
    tcp_msg_c: cover property (start_msg && tcp_port ##[1:20] o_msg_done);
    err_query_c: cover property (o_err_pending ##1 o_err_report);
    crlf_c: cover property (term_hit && rx_cr);
    late_c: cover property (o_resp_late);
endmodule

// >>> rtl/rmfe_cfg.svh
// Purpose: Constants of the remote message front end: characters, ports, times and cycle counts.
// Assumes: Core clock of 50 MHz; all times run on the internal time base.
// Notes:   Definitions only; included by bare name.
//
// Operation
// - Device answers queries within about 5 ms USB, 10 ms Ethernet, 2 ms CAN.
// - Port 502 takes only Modbus TCP; other ports take Modbus RTU or SCPI.
// - Off port 502, the first byte picks Modbus RTU or SCPI handling.
// - Port 502 needs the seven-byte MBAP header; other frames there are errors.
// - GPIB link takes SCPI only; USB takes both SCPI and Modbus RTU.
// - A byte gap of the set timeout ends a message; split commands become separate.
// - Inter-byte timeout is settable from the local menu and by remote command.
// - Without terminator, processing starts only after the full gap after the last byte.
// - SCPI LF, CR or CRLF ends the gap wait at once and releases the message.
// - An idle socket is closed after the set idle period; reconnect any time.
// - Set values from every location are checked against the adjustment limits.
// - SCPI limit errors are held until the host queries them, never sent unasked.
// - Serial and Ethernet take both protocols; CAN takes modified Modbus RTU only.
// - First byte 1 to 41 is a Modbus error; 42 and above is SCPI text.
// - Socket idle timeout defaults to 5 s, may be raised; keep-alive disables it.
`ifndef RMFE_CFG_SVH
`define RMFE_CFG_SVH

`define RMFE_CLK_HZ          50000000
`define RMFE_TICK_TIME_MS    1
`define RMFE_MS_CYCLES       ((`RMFE_CLK_HZ / 1000) * `RMFE_TICK_TIME_MS)
`define RMFE_MS_PER_S        1000
`define RMFE_GAP_DEFAULT_MS  8'h05
`define RMFE_IDLE_DEFAULT_S  8'h05
`define RMFE_RESP_USB_MS     8'h05
`define RMFE_RESP_ETH_MS     8'h0A
`define RMFE_RESP_CAN_MS     8'h02
`define RMFE_MBTCP_PORT      16'h01F6
`define RMFE_RTU_ADDR        8'h00
`define RMFE_SCPI_MIN        8'h2A
`define RMFE_CHAR_LF         8'h0A
`define RMFE_CHAR_CR         8'h0D
`define RMFE_MBAP_PID_LO     3'h2
`define RMFE_MBAP_PID_HI     3'h3
`define RMFE_MBTCP_MIN_BYTES 3'h7

`endif

// >>> rtl/rmfe_idle_timers.sv
// Purpose: One idle timer per socket; pulses a close request when a socket stays silent.
// Assumes: Second enable from the tick generator; socket indices are in range.
// Notes:   Resolution is one second, so a close comes between timeout-1 and timeout s.
`timescale 1ns/100ps
`include "rmfe_cfg.svh"
module rmfe_idle_timers #(
    parameter int NUM_SOCK = 4,
    parameter int SW       = 2
) (
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_b,
    // Time base and setting
    input  wire logic                i_s_tick,
    input  wire logic [7:0]          i_timeout_s,
    input  wire logic                i_keep_alive,
    // Socket traffic
    input  wire logic [NUM_SOCK-1:0] i_sock_open,
    input  wire logic                i_rx_valid,
    input  wire logic [SW-1:0]       i_rx_sock,
    input  wire logic                i_tx_valid,
    input  wire logic [SW-1:0]       i_tx_sock,
    // Close requests
    output logic [NUM_SOCK-1:0]      o_close
);
    logic [7:0] idle_reg [NUM_SOCK];

    // Timeout may be raised but never set below the default
    wire [7:0] limit_s = (i_timeout_s < `RMFE_IDLE_DEFAULT_S) ? `RMFE_IDLE_DEFAULT_S : i_timeout_s;

    // Per-socket counters; traffic either way restarts only its own socket
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_close <= '0;
            for (int s = 0; s < NUM_SOCK; s++) begin
                idle_reg[s] <= 8'h00;
            end
        end else begin
            for (int s = 0; s < NUM_SOCK; s++) begin
                o_close[s] <= 1'b0;
                if (!i_sock_open[s] || (i_rx_valid && i_rx_sock == SW'(s)) ||
                    (i_tx_valid && i_tx_sock == SW'(s))) begin
                    idle_reg[s] <= 8'h00;
                end else if (i_s_tick) begin
                    if (idle_reg[s] == limit_s - 8'h01) begin
                        idle_reg[s] <= 8'h00;
                        o_close[s]  <= !i_keep_alive;
                    end else begin
                        idle_reg[s] <= idle_reg[s] + 8'h01;
                    end
                end
            end
        end
    end

    idle_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_rx_valid && i_sock_open[i_rx_sock]) |=> idle_reg[$past(i_rx_sock)] == 8'h00)
        else $error("rx byte did not restart idle timer");
    keep_alive_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_keep_alive |=> o_close == '0) else $error("close under keep-alive");
endmodule

// >>> rtl/rmfe_pkg.sv
// Purpose: Types shared by the remote message front end.
// Assumes: Used by full name only, never imported.
// Notes:   Receive states follow a Gray path idle, body, terminator.
package rmfe_pkg;

    typedef enum logic [2:0] {
        LINK_USB    = 3'h0,
        LINK_SERIAL = 3'h1,
        LINK_ETH    = 3'h2,
        LINK_CAN    = 3'h3,
        LINK_GPIB   = 3'h4
    } link_type;

    typedef enum logic [1:0] {
        PROTO_RTU  = 2'h0,
        PROTO_SCPI = 2'h1,
        PROTO_TCP  = 2'h2,
        PROTO_ERR  = 2'h3
    } proto_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_BODY = 2'h1,
        RX_TERM = 2'h3
    } rx_state_type;

endpackage

// >>> rtl/rmfe_tick_gen.sv
// Purpose: Millisecond and second enable pulses from the core clock.
// Assumes: Free running from reset release.
// Notes:   One-cycle pulses; the second pulse coincides with a millisecond pulse.
`timescale 1ns/100ps
module rmfe_tick_gen #(
    parameter int MS_CYCLES = 50000,
    parameter int MS_PER_S  = 1000
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // Enables
    output logic      o_ms_tick,
    output logic      o_s_tick
);
    localparam int CW = $clog2(MS_CYCLES + 1);
    localparam int MW = $clog2(MS_PER_S + 1);

    logic [CW-1:0] cyc_reg;
    logic [MW-1:0] ms_reg;
    wire           cyc_wrap = (cyc_reg == CW'(MS_CYCLES - 1));
    wire           ms_wrap  = cyc_wrap && (ms_reg == MW'(MS_PER_S - 1));

    // Divider chain
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc_reg   <= '0;
            ms_reg    <= '0;
            o_ms_tick <= 1'b0;
            o_s_tick  <= 1'b0;
        end else begin
            cyc_reg   <= cyc_wrap ? '0 : cyc_reg + 1'b1;
            ms_reg    <= ms_wrap ? '0 : (cyc_wrap ? ms_reg + 1'b1 : ms_reg);
            o_ms_tick <= cyc_wrap;
            o_s_tick  <= ms_wrap;
        end
    end

    tick_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_ms_tick |=> !o_ms_tick) else $error("ms tick longer than one cycle");
endmodule

// >>> testbench/host_model.sv
// Purpose: Host model feeding the receive stream.
// Assumes: One byte a cycle, launched just after a rising edge.
// Notes:   A released data line shows the inverted last byte.
`timescale 1ns/100ps
module host_model #(
    parameter int MS_CYCLES = 20
) (
    // Clock
    input  wire logic          i_core_clk,
    // Stream into the device
    output rmfe_pkg::link_type o_link,
    output logic [15:0]        o_rx_port,
    output logic               o_rx_valid,
    output logic [7:0]         o_rx_byte
);
    // Quiet stream at time zero
    initial begin
        o_link = rmfe_pkg::LINK_USB;
        o_rx_port = 16'h13A1;
        o_rx_valid = 1'b0;
        o_rx_byte = 8'h00;
    end
    // Pacing first when pace is set, so the device sees messages no closer than allowed; with pace clear a message can follow inside the gap
    task automatic send_msg(input logic [7:0] b [$], input rmfe_pkg::link_type l, input logic [15:0] p, input bit pace);
        if (pace)
            repeat (((l == rmfe_pkg::LINK_ETH) ? 30 : 20) * MS_CYCLES) @(posedge i_core_clk);
        foreach (b[i]) begin
            @(posedge i_core_clk);
            o_link <= l;
            o_rx_port <= p;
            o_rx_valid <= 1'b1;
            o_rx_byte <= b[i];
        end
        @(posedge i_core_clk);
        o_rx_valid <= 1'b0;
        o_rx_byte <= ~b[b.size()-1];
    endtask
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench of the message front end.
// Assumes: 20 cycles a millisecond, 4 milliseconds a second.
// Notes:   Seeded random traffic plus hand-picked boundary bytes.
`timescale 1ns/100ps
module tb_top;
    localparam int MSC = 20;
    logic clk = 1'b0, rst_b = 1'b0, rxv, fv, md, ce, sa, sr, ep, er, ok, ka = 1'b0, gl = 1'b0, gr = 1'b0;
    logic sv = 1'b0, ss = 1'b0, eq = 1'b0, tv = 1'b0, rs = 1'b0, lt, ff;
    logic [7:0] rb, gv, b0, fb, gm = 8'h00, isv = 8'h05;
    logic [7:0] corner [3] = '{8'h29, 8'h2A, 8'h00};
    logic [15:0] pt, val = 16'h0000, lo = 16'h0000, hi = 16'h0000;
    logic [3:0] so = 4'h0, sc;
    rmfe_pkg::link_type lk, rl;
    rmfe_pkg::proto_type pr;
    int fail_count = 0, checks_done = 0, seed = 56443, c, d0, nd = 0, ne = 0, nf = 0, nr = 0, nl = 0, nx = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    // Pulse tallies on the falling edge, clear of the rising-edge updates
    always @(negedge clk) begin
        nd += (md === 1'b1);
        ne += (ce === 1'b1);
        nf += (fv === 1'b1);
        nr += (er === 1'b1);
        nl += (lt === 1'b1);
        nx += (ff === 1'b1);
    end
    host_model #(.MS_CYCLES(MSC)) u_host_model (.i_core_clk(clk), .o_link(lk), .o_rx_port(pt), .o_rx_valid(rxv),
        .o_rx_byte(rb));
    remote_message_front_end #(.MS_CYCLES(MSC), .MS_PER_S(4)) u_remote_message_front_end (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_link(lk), .i_rx_port(pt), .i_rx_valid(rxv), .i_rx_byte(rb),
        .i_rx_sock(2'h0), .i_tx_valid(tv), .i_tx_sock(2'h0), .i_sock_open(so), .i_resp_sent(rs),
        .i_gap_local_wr(gl), .i_gap_remote_wr(gr), .i_gap_ms(gm), .i_idle_s(isv), .i_keep_alive(ka),
        .i_setv_valid(sv), .i_setv_value(val), .i_setv_scpi(ss), .i_lim_low(lo), .i_lim_high(hi),
        .i_err_query(eq), .o_fwd_valid(fv), .o_fwd_byte(fb), .o_fwd_first(ff), .o_msg_done(md), .o_msg_proto(pr),
        .o_comm_err(ce), .o_gap_value(gv), .o_sock_close(sc), .o_resp_late(lt), .o_setv_accept(sa),
        .o_setv_reject(sr), .o_err_pending(ep), .o_err_report(er));
    // Protocol expected off the Modbus TCP port
    function automatic rmfe_pkg::proto_type exp_proto(input logic [7:0] b, input rmfe_pkg::link_type l);
        if (b == 8'h00)
            return (l == rmfe_pkg::LINK_GPIB) ? rmfe_pkg::PROTO_ERR : rmfe_pkg::PROTO_RTU;
        if (b < 8'h2A)
            return rmfe_pkg::PROTO_ERR;
        return (l == rmfe_pkg::LINK_CAN) ? rmfe_pkg::PROTO_ERR : rmfe_pkg::PROTO_SCPI;
    endfunction
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for a message end; a hang fails the range check
    task wait_done(input int lo_c, input int hi_c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (md !== 1'b1 && c < 400);
        chk("end delay", 1, c >= lo_c && c <= hi_c);
        if (c >= 400)
            end_of_test();
    endtask
    task set_gap(input bit remote, input logic [7:0] v, input logic [7:0] e);
        @(posedge clk);
        gl <= !remote;
        gr <= remote;
        gm <= v;
        @(posedge clk);
        gl <= 1'b0;
        gr <= 1'b0;
        @(posedge clk);
        chk("gap value", e, gv);
    endtask
    task pulse(input int w);
        @(posedge clk);
        {rs, tv, eq, sv} <= 4'h1 << w;
        @(posedge clk);
        {rs, tv, eq, sv} <= 4'h0;
        @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("proto", rmfe_pkg::PROTO_RTU, pr);
        u_host_model.send_msg('{8'h2A, 8'h41, 8'h0A}, rmfe_pkg::LINK_USB, 16'h13A1, 1'b1);
        wait_done(1, 2);
        chk("forwarded", 2, nf);
        chk("firsts", 1, nx);
        chk("proto", rmfe_pkg::PROTO_SCPI, pr);
        d0 = nd;
        u_host_model.send_msg('{8'h2A}, rmfe_pkg::LINK_USB, 16'h13A1, 1'b1);
        repeat (5 * MSC - 10) @(posedge clk);
        u_host_model.send_msg('{8'h42}, rmfe_pkg::LINK_USB, 16'h13A1, 1'b0);
        chk("early end", d0, nd);
        wait_done(5 * MSC, 5 * MSC + 3);
        chk("fwd byte", 8'h42, fb);
        pulse(3);
        u_host_model.send_msg('{8'h2A}, rmfe_pkg::LINK_USB, 16'h13A1, 1'b1);
        repeat (5 * MSC + 10) @(posedge clk);
        chk("split count", d0 + 2, nd);
        chk("late answers", 1, nl);
        $display("delimiting done");
        set_gap(0, 8'h03, 8'h03);
        set_gap(1, 8'h00, 8'h01);
        set_gap(1, 8'h02, 8'h02);
        for (int i = 0; i < 12; i++) begin
            rl = rmfe_pkg::link_type'(3'($unsigned($random(seed)) % 5));
            b0 = (i < 3) ? corner[i] : 8'($unsigned($random(seed)) % 8'h30);
            d0 = ne;
            u_host_model.send_msg('{b0, 8'h05}, rl, 16'h13A1, 1'b1);
            wait_done(2 * MSC, 2 * MSC + 3);
            chk("proto", exp_proto(b0, rl), pr);
            chk("comm errors", d0 + (exp_proto(b0, rl) == rmfe_pkg::PROTO_ERR), ne);
        end
        u_host_model.send_msg('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h03}, rmfe_pkg::LINK_ETH,
            16'h01F6, 1'b1);
        wait_done(2 * MSC, 2 * MSC + 3);
        chk("proto", rmfe_pkg::PROTO_TCP, pr);
        d0 = ne;
        u_host_model.send_msg('{8'h2A, 8'h41}, rmfe_pkg::LINK_ETH, 16'h01F6, 1'b1);
        wait_done(2 * MSC, 2 * MSC + 3);
        chk("comm errors", d0 + 1, ne);
        $display("protocol pick done");
        repeat (8) begin
            lo <= 16'h4000 + 16'($unsigned($random(seed)) % 16'h8000);
            ss <= $random(seed);
            @(posedge clk);
            hi <= lo + 16'h0100;
            val <= lo - 16'h0080 + 16'($unsigned($random(seed)) % 16'h0200);
            @(posedge clk);
            ok = val >= lo && val <= hi;
            pulse(0);
            chk("accept", ok, sa);
            chk("reject", !ok && !ss, sr);
            chk("pending", !ok && ss, ep);
            d0 = nr;
            pulse(1);
            @(posedge clk);
            chk("reports", d0 + (!ok && ss), nr);
        end
        $display("limits done");
        so <= 4'h1;
        repeat (200) @(posedge clk);
        pulse(2);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (sc[0] !== 1'b1 && c < 500);
        chk("idle close", 1, c >= 310 && c <= 405);
        so <= 4'h0;
        ka <= 1'b1;
        @(posedge clk);
        so <= 4'h1;
        c = 0;
        repeat (500) @(posedge clk) c += (sc !== 4'h0);
        chk("close under keep-alive", 0, c);
        $display("idle done");
        end_of_test();
    end
endmodule
